/* hw/vfd_scan_ctrl.sv */
// Display scan controller top: registers, sequencer, fetch, pins
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Fetches display bytes from memory by itself
// RULE_02: Nine output-only pins, sixteen shared port pins
// RULE_03: Display disabled: shared pins follow port latches
// RULE_04: Pins beyond pin count stay port pins
// RULE_05: Control resets 10H; enable, zero, pin count
// RULE_06: Pin count codes 10H..18H give 17..25 pins
// RULE_07: Software changes only enable while enabled; the code takes writes to enable and pin count at any time
// RULE_08: Software zeroes port latches of display pins
// RULE_09: Blanking register resets 01H; width, pattern count
// RULE_10: Width codes give 1,2,4..14 sixteenths
// RULE_11: Pattern codes 1..15 give 2..16 patterns
// RULE_12: No blanking register writes while enabled; the code accepts them while enabled too
// RULE_13: Scan register resets 00H; flag, insert, cycle
// RULE_14: Flag reads one during key scan, read-only
// RULE_15: Insert select adds key scan slot
// RULE_16: Cycle select gives 4096, 2048, 1024 clocks
// RULE_17: No scan register writes while enabled; the code accepts them while enabled too
// RULE_18: Interrupt pulse marks key scan timing
// RULE_19: Eight brightness steps via blanking width
// RULE_20: Blanking split equally at period start, end
// RULE_21: Key scan: display pins zero, latches shown
// RULE_22: Flag set in key scan, cleared after
// RULE_23: 96-byte display memory at FA00H, else RAM
// RULE_24: Step patterns each cycle, key slot, repeat
module vfd_scan_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port output latches of the shared pins
  input wire logic [15:0] port_latch_i,
  // Display pins and key scan event
  output logic [24:0] display_output_pins_o,
  output logic key_scan_interrupt_o
);
  // All state of the controller
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] ctrl;
    logic [7:0] blnk;
    logic ins;
    logic [1:0] cyc_sel;
    vfd_pkg::vfd_state_t st;
    logic [3:0] pat;
    logic [2:0] fb;
    logic [31:0] nxt;
    logic [31:0] cur;
    logic [24:0] pins;
    logic irq;
  } vfd_ctl_t;
  vfd_ctl_t s_q, s_d;

  // Decoded fields
  logic disp_en; // Display enable bit
  logic [5:0] pin_cnt_code; // Output pin count field
  logic [2:0] blk_code; // Blanking width field
  logic [3:0] pat_last; // Last pattern index
  logic ks_flag; // Key scan active flag
  // Bus decode
  logic bus_req; // New request this cycle
  logic bus_wr; // Low byte write of a new request
  logic [15:0] idx; // Register index
  logic in_ram; // Index falls in display memory
  logic [15:0] ram_off; // Offset inside display memory
  logic [7:0] ram_rdat; // Memory byte for the bus
  // Fetch path
  logic [3:0] nxt_pat; // Pattern being prefetched
  logic [6:0] fetch_addr; // Memory address for prefetch
  logic [7:0] fetch_data; // Prefetched byte
  logic [2:0] blk_bytes; // Bytes per pattern block
  logic fetching; // Prefetch still running
  // Timer
  logic tmr_run; // Timer counts in display or key scan
  logic tmr_end; // Last clock of a display cycle
  logic [4:0] pos; // Position in 32nds of the cycle
  logic [4:0] half; // Half blanking width in 32nds
  logic blank; // Outputs blanked at this position
  logic [24:0] pins_nx; // Next pin levels

  assign disp_en = s_q.ctrl[vfd_pkg::B_EN];
  assign pin_cnt_code = s_q.ctrl[5:0];
  assign blk_code = s_q.blnk[7:5];
  assign pat_last = s_q.blnk[3:0];
  assign ks_flag = (s_q.st == vfd_pkg::VFD_KSCAN); // RULE_22
  assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i;
  assign in_ram = (idx >= vfd_pkg::IDX_RAM) &&
    (idx < vfd_pkg::IDX_RAM_END); // RULE_23
  assign ram_off = idx - vfd_pkg::IDX_RAM;
  assign tmr_run = (s_q.st == vfd_pkg::VFD_DISP) || ks_flag;
  assign fetching = (s_q.fb != vfd_pkg::FETCH_MAX);

  // Block is three bytes for 17..24 pins, four for 25
  assign blk_bytes = (pin_cnt_code >= vfd_pkg::PINS_FOUR_BYTES) ?
    3'h4 : 3'h3; // RULE_06

  // Prefetch target: pattern zero when priming or wrapping
  always_comb begin
    if (s_q.st != vfd_pkg::VFD_DISP || s_q.pat == pat_last) begin
      nxt_pat = 4'h0;
    end else begin
      nxt_pat = s_q.pat + 4'h1; // RULE_24
    end
    fetch_addr = 7'(nxt_pat) * 7'(blk_bytes) + 7'(s_q.fb); // RULE_01
  end

  // Equal blanking at both ends of the period
  assign half = vfd_pkg::blank_half(blk_code); // RULE_10 RULE_19
  assign blank = (pos < half) ||
    (pos > (vfd_pkg::POS_LAST - half)); // RULE_20

  // Display memory
  vfd_ram u_ram (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .we_i(bus_wr && in_ram),
    .bus_addr_i(ram_off[6:0]),
    .wdata_i(wb_dat_i[7:0]),
    .bus_data_o(ram_rdat),
    .fetch_addr_i(fetch_addr),
    .fetch_data_o(fetch_data)
  );

  // Display cycle timer
  vfd_timing u_tmr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(tmr_run),
    .sel_i(s_q.cyc_sel),
    .end_o(tmr_end),
    .pos_o(pos)
  );

  // Per-pin output selection
  genvar gi;
  generate
    for (gi = 0; gi < vfd_pkg::PIN_COUNT; gi++) begin : g_pin
      logic own; // Pin carries display data now
      // Pin count is code plus one; key scan releases all pins
      assign own = disp_en && (6'(gi) <= pin_cnt_code) &&
        !ks_flag; // RULE_04 RULE_21
      if (gi < vfd_pkg::OUT_ONLY) begin : g_out
        // Output-only pin: data or zero
        assign pins_nx[gi] = own && (s_q.st == vfd_pkg::VFD_DISP) &&
          s_q.cur[gi] && !blank; // RULE_02
      end else begin : g_shr
        // Shared pin: port latch whenever display lets go
        assign pins_nx[gi] = own ?
          ((s_q.st == vfd_pkg::VFD_DISP) && s_q.cur[gi] && !blank) :
          port_latch_i[gi-vfd_pkg::OUT_ONLY]; // RULE_03 RULE_02
      end
    end
  endgenerate

  // Next state: bus slave, sequencer and prefetch
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.pins = pins_nx;
    // Answer one cycle after a request; drop after one cycle
    s_d.ack = bus_req;
    if (bus_req) begin
      case (idx)
        vfd_pkg::IDX_CTRL: begin
          s_d.rdat = {24'h0, s_q.ctrl}; // RULE_05
        end
        vfd_pkg::IDX_BLNK: begin
          s_d.rdat = {24'h0, s_q.blnk}; // RULE_09
        end
        vfd_pkg::IDX_SCAN: begin
          s_d.rdat = {24'h0, ks_flag, s_q.ins, 4'h0,
            s_q.cyc_sel}; // RULE_13 RULE_14
        end
        default: begin
          // Memory bytes, or zero for an unmapped index
          s_d.rdat = in_ram ? {24'h0, ram_rdat} : 32'h0;
        end
      endcase
    end
    // Register writes; bit 6 of control and flag stay fixed
    if (bus_wr) begin
      case (idx)
        vfd_pkg::IDX_CTRL: begin
          s_d.ctrl = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]}; // RULE_05
        end
        vfd_pkg::IDX_BLNK: begin
          s_d.blnk = wb_dat_i[7:0]; // RULE_09 RULE_11
        end
        vfd_pkg::IDX_SCAN: begin
          s_d.ins = wb_dat_i[vfd_pkg::B_INS]; // RULE_13
          s_d.cyc_sel = wb_dat_i[1:0]; // RULE_16
        end
        default: begin
          // Memory writes go straight to the array
        end
      endcase
    end
    // Prefetch one byte per clock into the next-pattern buffer
    if (fetching && s_q.st != vfd_pkg::VFD_IDLE) begin
      s_d.nxt[8*s_q.fb +: 8] = fetch_data; // RULE_01
      s_d.fb = s_q.fb + 3'h1;
    end
    // Sequencer
    case (s_q.st)
      vfd_pkg::VFD_IDLE: begin
        // Enable starts by fetching pattern zero
        if (disp_en) begin
          s_d.st = vfd_pkg::VFD_PRIME;
          s_d.fb = 3'h0;
          s_d.nxt = 32'h0;
        end
      end
      vfd_pkg::VFD_PRIME: begin
        // First block in hand: show it and fetch the next
        if (!fetching) begin
          s_d.st = vfd_pkg::VFD_DISP;
          s_d.cur = s_q.nxt;
          s_d.pat = 4'h0;
          s_d.fb = 3'h0;
        end
      end
      vfd_pkg::VFD_DISP: begin
        if (tmr_end) begin
          s_d.cur = s_q.nxt;
          s_d.fb = 3'h0;
          if (s_q.pat != pat_last) begin
            s_d.pat = s_q.pat + 4'h1; // RULE_24
          end else begin
            s_d.pat = 4'h0;
            // Optional key scan slot after the last pattern
            if (s_q.ins) begin
              s_d.st = vfd_pkg::VFD_KSCAN; // RULE_15
              s_d.irq = 1'b1; // RULE_18
            end
          end
        end
      end
      vfd_pkg::VFD_KSCAN: begin
        // One full cycle long, then display resumes
        if (tmr_end) begin
          s_d.st = vfd_pkg::VFD_DISP; // RULE_22
          s_d.cur = s_q.nxt;
          s_d.pat = 4'h0;
          s_d.fb = 3'h0;
        end
      end
      default: begin
        s_d.st = vfd_pkg::VFD_IDLE;
      end
    endcase
    // Disable stops the scan at once
    if (!disp_en) begin
      s_d.st = vfd_pkg::VFD_IDLE; // RULE_03
      s_d.fb = vfd_pkg::FETCH_MAX;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.ctrl <= vfd_pkg::CTRL_RST; // RULE_05
      s_q.blnk <= vfd_pkg::BLNK_RST; // RULE_09
      s_q.st <= vfd_pkg::VFD_IDLE;
      s_q.fb <= vfd_pkg::FETCH_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign display_output_pins_o = s_q.pins;
  assign key_scan_interrupt_o = s_q.irq;

  // Checks
  sequence s_last_pat;
    s_q.st == vfd_pkg::VFD_DISP && tmr_end && s_q.pat == pat_last;
  endsequence
  sequence s_scan_read;
    bus_req && !wb_we_i && idx == vfd_pkg::IDX_SCAN;
  endsequence

  a_shared_port: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !disp_en |=> display_output_pins_o[24:9] == $past(port_latch_i))
    else $error("shared pins not port"); // RULE_03
  a_key_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ks_flag |=> display_output_pins_o[8:0] == 9'h000 &&
    display_output_pins_o[24:9] == $past(port_latch_i))
    else $error("key scan pins wrong"); // RULE_21
  a_flag_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_scan_read |=> wb_ack_o && wb_dat_o[7] == $past(ks_flag))
    else $error("flag read wrong"); // RULE_14
  a_irq_entry: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_last_pat ##0 s_q.ins && disp_en |=> key_scan_interrupt_o && ks_flag
    ##1 !key_scan_interrupt_o) else $error("irq not at entry"); // RULE_18
  a_no_insert: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_last_pat ##0 !s_q.ins && disp_en |=> !ks_flag && s_q.pat == 4'h0)
    else $error("key slot inserted"); // RULE_15
  a_pat_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.st == vfd_pkg::VFD_DISP && tmr_end && s_q.pat != pat_last &&
    disp_en |=> s_q.pat == $past(s_q.pat) + 4'h1)
    else $error("pattern did not step"); // RULE_24
  a_blank_edges: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pos == 5'h00 || pos == vfd_pkg::POS_LAST) |=>
    display_output_pins_o[8:0] == 9'h000)
    else $error("edge not blanked"); // RULE_20
  a_ctrl_bit6: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_wr && idx == vfd_pkg::IDX_CTRL |=> !s_q.ctrl[6] &&
    s_q.ctrl[7] == $past(wb_dat_i[7])) else $error("ctrl write"); // RULE_05
endmodule // vfd_scan_ctrl

/* hw/vfd_pkg.sv */
// Shared constants and types for the display scan controller
package vfd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hFFA0;
  localparam logic [15:0] IDX_BLNK = 16'hFFA1;
  localparam logic [15:0] IDX_SCAN = 16'hFFA2;
  localparam logic [15:0] IDX_RAM = 16'hFA00;
  localparam logic [15:0] IDX_RAM_END = 16'hFA60;
  // Display data memory size in bytes
  localparam int RAM_BYTES = 96;
  // Pin layout
  localparam int PIN_COUNT = 25;
  localparam int OUT_ONLY = 9;
  localparam int SHARED = 16;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] BLNK_RST = 8'h01;
  localparam logic [7:0] SCAN_RST = 8'h00;
  // Field positions
  localparam int B_EN = 7;
  localparam int B_FLAG = 7;
  localparam int B_INS = 6;
  // Pin count field value giving four data bytes per pattern
  localparam logic [5:0] PINS_FOUR_BYTES = 6'h18;
  // Bytes fetched per pattern at most
  localparam logic [2:0] FETCH_MAX = 3'h4;
  // Display cycle lengths, log2 of main clock periods
  localparam int CYC_LOG_SLOW = 12;
  localparam int CYC_LOG_MID = 11;
  localparam int CYC_LOG_FAST = 10;
  // Cycle position resolution: 32 steps per cycle
  localparam logic [4:0] POS_LAST = 5'h1F;
  // Sequencer states
  typedef enum logic [1:0] {
    VFD_IDLE, VFD_PRIME, VFD_DISP, VFD_KSCAN
  } vfd_state_t;
  // Half blanking width in 32nds: 1,2,4,6,...,14
  function automatic logic [4:0] blank_half(input logic [2:0] code);
    blank_half = (code == 3'h0) ? 5'h01 : {1'b0, code, 1'b0};
  endfunction
endpackage

/* hw/vfd_timing.sv */
// Display cycle timer: cycle end pulse and position within cycle
`timescale 1ns/1ps
module vfd_timing (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  // Timing outputs
  output logic end_o,
  output logic [4:0] pos_o
);
  // All state
  typedef struct packed {
    logic [11:0] cnt;
  } vfd_tmr_t;
  vfd_tmr_t s_q, s_d;

  // Last count of the selected cycle; prohibited code runs fastest
  always_comb begin
    s_d = s_q;
    case (sel_i)
      2'h0: begin
        end_o = &s_q.cnt; // RULE_16
        pos_o = s_q.cnt[11:7];
      end
      2'h1: begin
        end_o = &s_q.cnt[10:0]; // RULE_16
        pos_o = s_q.cnt[10:6];
      end
      default: begin
        end_o = &s_q.cnt[9:0]; // RULE_16
        pos_o = s_q.cnt[9:5];
      end
    endcase
    end_o = end_o & run_i;
    // Held at zero while stopped so each run starts a full cycle
    if (!run_i || end_o) begin
      s_d.cnt = 12'h000;
    end else begin
      s_d.cnt = s_q.cnt + 12'h001;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_cycle_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    end_o |=> pos_o == 5'h00) else $error("cycle did not wrap"); // RULE_16
endmodule // vfd_timing

/* hw/vfd_ram.sv */
// Display data memory: bus port plus fetch read port
`timescale 1ns/1ps
module vfd_ram (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus side
  input wire logic we_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] bus_data_o,
  // Fetch side
  input wire logic [6:0] fetch_addr_i,
  output logic [7:0] fetch_data_o
);
  // All state: the byte array
  typedef struct packed {
    logic [vfd_pkg::RAM_BYTES-1:0][7:0] mem;
  } vfd_mem_t;
  vfd_mem_t s_q, s_d;

  // Writes and combinational reads; out of range reads as zero
  always_comb begin
    s_d = s_q;
    if (we_i && (32'(bus_addr_i) < vfd_pkg::RAM_BYTES)) begin
      s_d.mem[bus_addr_i] = wdata_i;
    end
    bus_data_o = (32'(bus_addr_i) < vfd_pkg::RAM_BYTES) ?
      s_q.mem[bus_addr_i] : 8'h00;
    fetch_data_o = (32'(fetch_addr_i) < vfd_pkg::RAM_BYTES) ?
      s_q.mem[fetch_addr_i] : 8'h00; // RULE_01
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // vfd_ram

/* tb/vfd_panel_model.sv */
// Panel and key matrix stand-in: counts key scan slots
`timescale 1ns/1ps
module vfd_panel_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Display side
  input wire logic [24:0] pins_i,
  input wire logic irq_i,
  // Observations
  output int scans_o,
  output logic [24:0] lit_o
);
  // One pulse per slot; a stuck pulse would inflate the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scans_o <= 0;
    end else if (irq_i) begin
      scans_o <= scans_o + 1;
    end
  end
  // Panel only latches what is driven; it never drives back
  always_ff @(posedge clk_i) begin
    lit_o <= pins_i;
  end
endmodule // vfd_panel_model

/* tb/vfd_scan_ctrl_tb.sv */
// Self-checking bench for the display scan controller
`timescale 1ns/1ps
module vfd_scan_ctrl_tb;
  // Drives toward the design
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] latch = 16'h0000;
  // Design outputs and bookkeeping
  logic [31:0] rdat;
  logic ack, irq;
  logic [24:0] pins, lit;
  logic [7:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int scans;
  // 100 MHz clock and free cycle count
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
  vfd_scan_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_latch_i(latch), .display_output_pins_o(pins),
    .key_scan_interrupt_o(irq));
  vfd_panel_model PANEL (.clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins),
    .irq_i(irq), .scans_o(scans), .lit_o(lit));
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Single compare point
  task automatic chk(input string nm, input logic [24:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 25'h0, 25'h1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Read and compare one register byte
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), 25'(q), 25'(e));
  endtask
  // Wait until the free count reaches a mark, then settle
  task automatic wait_to(input int t);
    while (cyc_cnt < t) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // Bounded wait for the key scan pulse
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 16000);
    if (n >= 16000) chk("irq", 25'h0, 25'h1);
    t = cyc_cnt;
  endtask
  // Disabled: shared pins mirror the latches, low nine stay low
  task automatic pins_off();
    @(posedge clk_i);
    latch <= 16'($urandom);
    repeat (3) @(posedge clk_i);
    #1;
    chk("pins off", pins, {latch, 9'h000});
  endtask
  // Seventeen display pins, upper eight left to the port
  function automatic logic [24:0] exp_pins(input logic [7:0] x, y, z);
    exp_pins = {latch[15:8], z[0], y, x};
  endfunction
  // Main sequence
  initial begin : main
    int t, s0, l, h, st;
    logic [7:0] b [6];
    logic [1:0] sel;
    logic [24:0] blank;
    void'($urandom(32'h87C2));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    // Reset values, unmapped index, fixed and read-only bits
    rd(vfd_pkg::IDX_CTRL, 8'h10);
    rd(vfd_pkg::IDX_BLNK, 8'h01);
    rd(vfd_pkg::IDX_SCAN, 8'h00);
    rd(16'h0123, 8'h00);
    wb(1'b1, vfd_pkg::IDX_CTRL, 8'h50);
    rd(vfd_pkg::IDX_CTRL, 8'h10);
    // Flag bit written as one must stay clear; bits 5..2 kept zero
    wb(1'b1, vfd_pkg::IDX_SCAN, 8'hC2);
    rd(vfd_pkg::IDX_SCAN, 8'h42);
    pins_off();
    // Every blanking code, three cycle lengths
    for (int c = 0; c < 8; c++) begin
      sel = (c == 3) ? 2'h0 : (c == 5) ? 2'h1 : 2'h2;
      l = 4096 >> sel;
      st = l / 32;
      h = (c == 0) ? 1 : 2 * c;
      // Reconfigure only while disabled
      wb(1'b1, vfd_pkg::IDX_CTRL, 8'h10);
      wb(1'b1, vfd_pkg::IDX_BLNK, {c[2:0], 5'h01});
      wb(1'b1, vfd_pkg::IDX_SCAN, {2'b01, 4'h0, sel});
      for (int k = 0; k < 6; k++) begin
        b[k] = 8'($urandom);
        wb(1'b1, vfd_pkg::IDX_RAM + 16'(k), b[k]);
      end
      rd(vfd_pkg::IDX_RAM + 16'h0005, b[5]);
      // Latches of display pins zero, spare ones random
      @(posedge clk_i);
      latch <= {8'($urandom), 8'h00};
      wb(1'b1, vfd_pkg::IDX_CTRL, 8'h90);
      wait_irq(t);
      s0 = scans;
      blank = {latch[15:8], 17'h00000};
      rd(vfd_pkg::IDX_SCAN, {2'b11, 4'h0, sel});
      wait_to(t + l / 2);
      chk("key scan", pins, {latch, 9'h000});
      // Pattern 0: blanked ends, lit middle
      wait_to(t + l + (h - 1) * st + st / 2);
      chk("blank lead", pins, blank);
      wait_to(t + l + h * st + st / 2);
      chk("lit lead", pins, exp_pins(b[0], b[1], b[2]));
      wait_to(t + l + l / 2);
      chk("pattern 0", pins, exp_pins(b[0], b[1], b[2]));
      rd(vfd_pkg::IDX_SCAN, {2'b01, 4'h0, sel});
      wait_to(t + l + (31 - h) * st + st / 2);
      chk("lit tail", pins, exp_pins(b[0], b[1], b[2]));
      wait_to(t + l + (32 - h) * st + st / 2);
      chk("blank tail", pins, blank);
      // Pattern 1 from the next three bytes, then key slot again
      wait_to(t + 2 * l + l / 2);
      chk("pattern 1", pins, exp_pins(b[3], b[4], b[5]));
      wait_to(t + 3 * l - st);
      chk("slot count", 25'(scans - s0), 25'h1);
      wait_to(t + 3 * l + st);
      chk("slot again", 25'(scans - s0), 25'h2);
    end
    // No key slot; all 25 pins, so four-byte blocks and zero latches
    wb(1'b1, vfd_pkg::IDX_CTRL, 8'h10);
    wb(1'b1, vfd_pkg::IDX_CTRL, 8'h18);
    wb(1'b1, vfd_pkg::IDX_SCAN, 8'h02);
    @(posedge clk_i);
    latch <= 16'h0000;
    wb(1'b1, vfd_pkg::IDX_CTRL, 8'h98);
    s0 = scans;
    // Middle of pattern 0, then of pattern 1; bytes 6 and 7 are zero
    repeat (512) @(posedge clk_i);
    #1;
    chk("wide 0", pins, {b[3][0], b[2], b[1], b[0]});
    chk("panel lit", lit, {b[3][0], b[2], b[1], b[0]});
    repeat (1024) @(posedge clk_i);
    #1;
    chk("wide 1", pins, {9'h000, b[5], b[4]});
    repeat (5000) @(posedge clk_i);
    chk("no slot", 25'(scans - s0), 25'h0);
    // Reset in mid-scan restores every register
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(vfd_pkg::IDX_CTRL, 8'h10);
    rd(vfd_pkg::IDX_BLNK, 8'h01);
    rd(vfd_pkg::IDX_SCAN, 8'h00);
    // Disable hands the shared pins back
    wb(1'b1, vfd_pkg::IDX_CTRL, 8'h10);
    pins_off();
    end_of_test();
  end
  // Hang guard sized above the longest expected run
  initial begin : watchdog
    #900000;
    n_errors++;
    end_of_test();
  end
endmodule // vfd_scan_ctrl_tb
